/* common/msib_defines.svh */
// Constants shared by both ends of the management serial bridge.
// Assumes it is included by its bare name.
`ifndef MSIB_DEFINES_SVH
`define MSIB_DEFINES_SVH

// Indirect register addresses on the serial link.
`define MS_R_ALO 5'h00
`define MS_R_AHI 5'h01
`define MS_R_DLO 5'h02
`define MS_R_DHI 5'h03
`define MS_R_DINC 5'h04
`define MS_R_DPAS 5'h05
`define MS_R_STAT 5'h06
// Status bits of the indirect status register.
`define MS_ST_BUSY 0
`define MS_ST_BUSYRD 1
`define MS_ST_ERR 2
// Error and busy patterns.
`define MS_ERR_HALF 16'h8888
`define MS_ERR_WORD 32'h88888888
// Frame fields.
`define MS_OP_WR 2'h1
`define MS_OP_RD 2'h2
`define MS_HDR_LAST 4'hb
`define MS_TA_LAST 4'h1
`define MS_DATA_LAST 4'hf
`define MS_PHY_A 5'h01
`define MS_PHY_B 5'h02
// Window block: word page and word index of each register.
`define MS_WIN_PAGE 29'h001fff00
`define MS_W_CTRL 3'h0
`define MS_W_ADDR 3'h1
`define MS_W_DATA 3'h2
`define MS_W_INC 3'h3
`define MS_W_PAS 3'h4
`define MS_WC_BUSY 0
`define MS_WC_ERR 1
`define MS_WIN_STEP 32'h00000004
// Host command registers on APB.
`define MS_A_CMD 12'h000
`define MS_A_STAT 12'h004
`define MS_A_RDATA 12'h008
`define MS_A_PHY 12'h00c
`define MS_CMD_REG 20:16
`define MS_CMD_RD 24
// Host frame layout, counted from the first preamble bit.
`define MS_PRE 32'hffffffff
`define MS_TA_WR 2'h2
`define MS_BIT_TA 6'd46
`define MS_BIT_DATA 6'd48
`define MS_BIT_LAST 6'd63
// Serial clock made by the host.
`define MS_PCLK_NS 10
`define MS_MDC_NS 160
`define MS_HALF_CYC ((`MS_MDC_NS / `MS_PCLK_NS) / 2)

`endif

/* common/msib_link_if.sv */
// Serial management link between host and device ends.
// Assumes a pull-up on the data line; the host makes the clock.
`timescale 1ns/1ns
interface msib_link_if;
    logic mgmt_slave_clock_in;
    logic host_data_o;
    logic host_data_oe;
    logic dev_data_o;
    logic dev_data_oe;
    logic mgmt_slave_data_io;
    // Open-drain style wire with a pull-up.
    assign mgmt_slave_data_io = (host_data_oe ? host_data_o : 1'b1) & (dev_data_oe ? dev_data_o : 1'b1);
    modport host (
        output mgmt_slave_clock_in, host_data_o, host_data_oe,
        input mgmt_slave_data_io
    );
    modport device (
        input mgmt_slave_clock_in, mgmt_slave_data_io,
        output dev_data_o, dev_data_oe
    );
endinterface

/* common/msib_pkg.sv */
// Types shared by both ends of the management serial bridge.
// Assumes nothing of its surroundings.
package msib_pkg;
    typedef enum logic [2:0] {
        MSIB_DS_IDLE = 3'h0,
        MSIB_DS_START = 3'h1,
        MSIB_DS_HDR = 3'h2,
        MSIB_DS_TA = 3'h3,
        MSIB_DS_DATA = 3'h4
    } msib_dev_state_t;
    typedef enum logic {
        MSIB_HS_IDLE = 1'b0,
        MSIB_HS_RUN = 1'b1
    } msib_host_state_t;
    typedef logic [15:0] msib_half_t;
endpackage

/* core/msib_device.sv */
// Device end: serial management slave with indirect register access and
// the shared-bus window.
// Assumes the link clock comes from the host and all user inputs are on pclk.
//
// Function
// - Sample and change data on clock rise
// - Frames use standard management frame format
// - Answer only the selected PHY address
// - Seven 16-bit registers at addresses 0..6
// - Master loads word address in two writes
// - Write high data half launches write
// - Reading high half launches read, returns previous
// - Register 4 launches, then address increments
// - Register 5 never launches an access
// - Error reads of registers 2 to 5, and busy reads of registers 3 and 4, return 0x8888
// - Status shows busy, last busy, error
// - Master masks and shifts byte address
// - Window data write starts bus write
// - Window data read starts bus read
// - Autoincrement alias advances address by four
// - Passive alias never starts bus access
// - Bus error sets flag, loads pattern
// - Busy window views return eights pattern
// - Master rechecks eights pattern via passive
// - Increment only on non-busy accepted reads and writes
// - Strap enables pin takeover
//
// Register access over APB was decided locally.
`include "msib_defines.svh"
`timescale 1ns/1ns
module msib_device (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Serial link.
    msib_link_if.device link,
    // Straps and configuration.
    input wire logic strap_slave_en,
    input wire logic strap_addr_sel,
    input wire logic phy_address_choice,
    output logic pin_takeover,
    // Internal register bus.
    output logic csr_req,
    output logic csr_wr,
    output logic [31:0] csr_addr,
    output logic [31:0] csr_wdata,
    input wire logic csr_ack,
    input wire logic csr_err,
    input wire logic [31:0] csr_rdata,
    // Shared system bus.
    output logic shb_req,
    output logic shb_wr,
    output logic [31:0] shb_addr,
    output logic [31:0] shb_wdata,
    input wire logic shb_ack,
    input wire logic shb_err,
    input wire logic [31:0] shb_rdata
);
    import msib_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic mdc1_q, mdc2_q, mdc3_q, dio1_q, dio2_q;
    logic strap_done_q, takeover_q, addr_sel_q;
    msib_dev_state_t state_q;
    logic [3:0] cnt_q;
    logic [11:0] hdr_q;
    msib_half_t rx_q, tx_q;
    logic [4:0] reg_q;
    logic hit_q, rdop_q, drv_q, dout_q;
    logic [31:0] addr_q, data_q, caddr_q;
    logic busy_q, busy_rd_q, err_q, wr_q, incr_q, loc_q, creq_q;
    logic [31:0] waddr_q, wdata_q, saddr_q, swdata_q;
    logic wbusy_q, werr_q, sreq_q, swr_q;
    logic mdc_rise, rd_evt, wr_evt, trig, launch, win_op;
    logic [11:0] hdr_d;
    msib_half_t rx_d, rd_val;
    logic [4:0] my_phy, ev_reg;
    logic [2:0] widx;
    logic [31:0] win_rd;

    ////////////////////////////////////////////////////////////////////////
    // Link inputs cross into pclk through two flip-flops each.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mdc1_q <= 1'b0;
            mdc2_q <= 1'b0;
            mdc3_q <= 1'b0;
            dio1_q <= 1'b1;
            dio2_q <= 1'b1;
        end else begin
            mdc1_q <= link.mgmt_slave_clock_in;
            mdc2_q <= mdc1_q;
            mdc3_q <= mdc2_q;
            dio1_q <= link.mgmt_slave_data_io;
            dio2_q <= dio1_q;
        end
    end

    // Straps are caught on the first clock after reset release.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_done_q <= 1'b0;
            takeover_q <= 1'b0;
            addr_sel_q <= 1'b0;
        end else if (!strap_done_q) begin
            strap_done_q <= 1'b1;
            takeover_q <= strap_slave_en;
            addr_sel_q <= strap_addr_sel;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        mdc_rise = mdc2_q && !mdc3_q;
        hdr_d = {hdr_q[10:0], dio2_q};
        rx_d = {rx_q[14:0], dio2_q};
        my_phy = (phy_address_choice || addr_sel_q) ? `MS_PHY_B : `MS_PHY_A;
        rd_evt = mdc_rise && state_q == MSIB_DS_HDR && cnt_q == `MS_HDR_LAST && hdr_d[11:10] == `MS_OP_RD
            && hdr_d[9:5] == my_phy && hdr_d[4:0] <= `MS_R_STAT;
        wr_evt = mdc_rise && state_q == MSIB_DS_DATA && cnt_q == `MS_DATA_LAST && hit_q && !rdop_q;
        ev_reg = rd_evt ? hdr_d[4:0] : reg_q;
        trig = (rd_evt || wr_evt) && (ev_reg == `MS_R_DHI || ev_reg == `MS_R_DINC);
        launch = trig && !busy_q;
        win_op = busy_q && loc_q;
        widx = caddr_q[2:0];
    end

    // Read value of the indirect registers.
    always_comb begin
        case (hdr_d[4:0])
            `MS_R_ALO: rd_val = addr_q[15:0];
            `MS_R_AHI: rd_val = addr_q[31:16];
            `MS_R_DLO: rd_val = err_q ? `MS_ERR_HALF : data_q[15:0];
            `MS_R_DHI, `MS_R_DINC: rd_val = (err_q || busy_q) ? `MS_ERR_HALF : data_q[31:16];
            `MS_R_DPAS: rd_val = err_q ? `MS_ERR_HALF : data_q[31:16];
            `MS_R_STAT: begin
                rd_val = '0;
                rd_val[`MS_ST_BUSY] = busy_q;
                rd_val[`MS_ST_BUSYRD] = busy_rd_q;
                rd_val[`MS_ST_ERR] = err_q;
            end
            default: rd_val = '0;
        endcase
    end

    // Read value of the window registers.
    always_comb begin
        case (widx)
            `MS_W_CTRL: begin
                win_rd = '0;
                win_rd[`MS_WC_BUSY] = wbusy_q;
                win_rd[`MS_WC_ERR] = werr_q;
            end
            `MS_W_ADDR: win_rd = waddr_q;
            `MS_W_DATA, `MS_W_INC, `MS_W_PAS: win_rd = wbusy_q ? `MS_ERR_WORD : wdata_q;
            default: win_rd = '0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Frame receiver and read data driver.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= MSIB_DS_IDLE;
            cnt_q <= 4'h0;
            hdr_q <= 12'h000;
            rx_q <= 16'h0000;
            tx_q <= 16'h0000;
            reg_q <= 5'h00;
            hit_q <= 1'b0;
            rdop_q <= 1'b0;
            drv_q <= 1'b0;
            dout_q <= 1'b1;
        end else if (!takeover_q) begin
            state_q <= MSIB_DS_IDLE;
            drv_q <= 1'b0;
        end else if (mdc_rise) begin
            case (state_q)
                MSIB_DS_IDLE: begin
                    if (!dio2_q) begin
                        state_q <= MSIB_DS_START;
                    end
                end
                MSIB_DS_START: begin
                    state_q <= dio2_q ? MSIB_DS_HDR : MSIB_DS_IDLE;
                    cnt_q <= 4'h0;
                end
                MSIB_DS_HDR: begin
                    hdr_q <= hdr_d;
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q == `MS_HDR_LAST) begin
                        cnt_q <= 4'h0;
                        reg_q <= hdr_d[4:0];
                        rdop_q <= hdr_d[11:10] == `MS_OP_RD;
                        hit_q <= hdr_d[9:5] == my_phy && hdr_d[4:0] <= `MS_R_STAT;
                        tx_q <= rd_val;
                        if (hdr_d[11:10] == `MS_OP_RD || hdr_d[11:10] == `MS_OP_WR) begin
                            state_q <= MSIB_DS_TA;
                        end else begin
                            state_q <= MSIB_DS_IDLE;
                        end
                    end
                end
                MSIB_DS_TA: begin
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q == `MS_TA_LAST) begin
                        cnt_q <= 4'h0;
                        state_q <= MSIB_DS_DATA;
                        drv_q <= hit_q && rdop_q;
                        dout_q <= tx_q[15];
                        tx_q <= {tx_q[14:0], 1'b0};
                    end
                end
                MSIB_DS_DATA: begin
                    rx_q <= rx_d;
                    cnt_q <= cnt_q + 4'h1;
                    dout_q <= tx_q[15];
                    tx_q <= {tx_q[14:0], 1'b0};
                    if (cnt_q == `MS_DATA_LAST) begin
                        drv_q <= 1'b0;
                        dout_q <= 1'b1;
                        state_q <= MSIB_DS_IDLE;
                    end
                end
                default: state_q <= MSIB_DS_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Indirect address, data and status; launches internal accesses.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_q <= 32'h00000000;
            data_q <= 32'h00000000;
            caddr_q <= 32'h00000000;
            busy_q <= 1'b0;
            busy_rd_q <= 1'b0;
            err_q <= 1'b0;
            wr_q <= 1'b0;
            incr_q <= 1'b0;
            loc_q <= 1'b0;
            creq_q <= 1'b0;
        end else begin
            if (wr_evt) begin
                case (reg_q)
                    `MS_R_ALO: addr_q[15:0] <= rx_d;
                    `MS_R_AHI: addr_q[31:16] <= rx_d;
                    `MS_R_DLO: data_q[15:0] <= busy_q ? data_q[15:0] : rx_d;
                    `MS_R_DHI, `MS_R_DINC, `MS_R_DPAS: data_q[31:16] <= busy_q ? data_q[31:16] : rx_d;
                    default: data_q <= data_q;
                endcase
            end
            if (trig) begin
                busy_rd_q <= busy_q;
            end
            if (launch) begin
                busy_q <= 1'b1;
                wr_q <= wr_evt;
                incr_q <= ev_reg == `MS_R_DINC;
                err_q <= 1'b0;
                caddr_q <= addr_q;
                loc_q <= addr_q[31:3] == `MS_WIN_PAGE;
                creq_q <= addr_q[31:3] != `MS_WIN_PAGE;
            end else if (win_op || (busy_q && csr_ack)) begin
                busy_q <= 1'b0;
                loc_q <= 1'b0;
                creq_q <= 1'b0;
                if (!win_op && csr_err) begin
                    err_q <= 1'b1;
                    data_q <= `MS_ERR_WORD;
                end else if (!wr_q) begin
                    data_q <= win_op ? win_rd : csr_rdata;
                end
                if (incr_q) begin
                    addr_q <= addr_q + 32'h00000001;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shared-bus window, reached at its word page through the indirect path.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            waddr_q <= 32'h00000000;
            wdata_q <= 32'h00000000;
            wbusy_q <= 1'b0;
            werr_q <= 1'b0;
            sreq_q <= 1'b0;
            swr_q <= 1'b0;
            saddr_q <= 32'h00000000;
            swdata_q <= 32'h00000000;
        end else begin
            if (win_op && wr_q && !wbusy_q) begin
                case (widx)
                    `MS_W_ADDR: waddr_q <= data_q;
                    `MS_W_DATA, `MS_W_INC, `MS_W_PAS: wdata_q <= data_q;
                    default: wdata_q <= wdata_q;
                endcase
            end
            if (win_op && wr_q && widx == `MS_W_CTRL && data_q[`MS_WC_ERR]) begin
                werr_q <= 1'b0;
            end
            if (win_op && !wbusy_q && (widx == `MS_W_DATA || widx == `MS_W_INC)) begin
                sreq_q <= 1'b1;
                swr_q <= wr_q;
                saddr_q <= waddr_q;
                swdata_q <= data_q;
                wbusy_q <= 1'b1;
                if (widx == `MS_W_INC) begin
                    waddr_q <= waddr_q + `MS_WIN_STEP;
                end
            end
            if (sreq_q && shb_ack) begin
                sreq_q <= 1'b0;
                wbusy_q <= 1'b0;
                if (shb_err) begin
                    werr_q <= 1'b1;
                    wdata_q <= `MS_ERR_WORD;
                end else if (!swr_q) begin
                    wdata_q <= shb_rdata;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign link.dev_data_o = dout_q;
    assign link.dev_data_oe = drv_q;
    assign pin_takeover = takeover_q;
    assign csr_req = creq_q;
    assign csr_wr = wr_q;
    assign csr_addr = caddr_q;
    assign csr_wdata = data_q;
    assign shb_req = sreq_q;
    assign shb_wr = swr_q;
    assign shb_addr = saddr_q;
    assign shb_wdata = swdata_q;
endmodule // msib_device

/* core/msib_host.sv */
// Host end: management station master driven by software over APB.
// Assumes APB on pclk and a device end on the far side of the link.
`include "msib_defines.svh"
`timescale 1ns/1ns
module msib_host (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial link.
    msib_link_if.host link
);
    import msib_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    localparam logic [3:0] HALF = 4'(`MS_HALF_CYC);
    localparam logic [3:0] LAST = 4'(2 * `MS_HALF_CYC - 1);
    msib_host_state_t state_q;
    logic rdy_q, err_q, mdc_q, dout_q, oe_q, rd_q, dio1_q, dio2_q;
    logic [31:0] prd_q;
    logic [4:0] phy_q;
    logic [63:0] frame_q;
    logic [5:0] bit_q;
    logic [3:0] ph_q;
    msib_half_t rdata_q;
    logic acc, wr_acc, mapped;
    logic [31:0] rd_mux;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        acc = psel && penable && !rdy_q;
        wr_acc = psel && penable && rdy_q && pwrite;
        mapped = paddr == `MS_A_CMD || paddr == `MS_A_STAT || paddr == `MS_A_RDATA || paddr == `MS_A_PHY;
        case (paddr)
            `MS_A_STAT: rd_mux = {31'h00000000, state_q == MSIB_HS_RUN};
            `MS_A_RDATA: rd_mux = {16'h0000, rdata_q};
            `MS_A_PHY: rd_mux = {27'h0000000, phy_q};
            default: rd_mux = 32'h00000000;
        endcase
    end

    // One wait state on every access; unmapped addresses answer with pslverr.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdy_q <= 1'b0;
            err_q <= 1'b0;
            prd_q <= 32'h00000000;
            phy_q <= `MS_PHY_A;
        end else begin
            rdy_q <= acc;
            if (acc) begin
                err_q <= !mapped;
                prd_q <= pwrite ? 32'h00000000 : rd_mux;
            end
            if (wr_acc && paddr == `MS_A_PHY) begin
                phy_q <= pwdata[4:0];
            end
        end
    end

    // Data line crosses into pclk through two flip-flops.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dio1_q <= 1'b1;
            dio2_q <= 1'b1;
        end else begin
            dio1_q <= link.mgmt_slave_data_io;
            dio2_q <= dio1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Frame engine: data changes on the clock fall so the device samples it
    // stable at the rise; read data is taken at the rise.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= MSIB_HS_IDLE;
            frame_q <= 64'h0000000000000000;
            bit_q <= 6'd0;
            ph_q <= 4'h0;
            mdc_q <= 1'b0;
            dout_q <= 1'b1;
            oe_q <= 1'b0;
            rd_q <= 1'b0;
            rdata_q <= 16'h0000;
        end else if (state_q == MSIB_HS_IDLE) begin
            if (wr_acc && paddr == `MS_A_CMD) begin
                state_q <= MSIB_HS_RUN;
                rd_q <= pwdata[`MS_CMD_RD];
                frame_q <= {`MS_PRE, 2'b01, pwdata[`MS_CMD_RD] ? `MS_OP_RD : `MS_OP_WR, phy_q,
                    pwdata[`MS_CMD_REG], `MS_TA_WR, pwdata[15:0]};
                bit_q <= 6'd0;
                ph_q <= 4'h0;
                dout_q <= 1'b1;
                oe_q <= 1'b1;
            end
        end else begin
            ph_q <= ph_q + 4'h1;
            if (ph_q == HALF - 4'h1) begin
                mdc_q <= 1'b1;
                if (rd_q && bit_q >= `MS_BIT_DATA) begin
                    rdata_q <= {rdata_q[14:0], dio2_q};
                end
            end
            if (ph_q == LAST) begin
                ph_q <= 4'h0;
                mdc_q <= 1'b0;
                bit_q <= bit_q + 6'd1;
                frame_q <= {frame_q[62:0], 1'b0};
                dout_q <= frame_q[62];
                oe_q <= !(rd_q && bit_q + 6'd1 >= `MS_BIT_TA);
                if (bit_q == `MS_BIT_LAST) begin
                    state_q <= MSIB_HS_IDLE;
                    oe_q <= 1'b0;
                    dout_q <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign prdata = prd_q;
    assign pready = rdy_q;
    assign pslverr = err_q;
    assign link.mgmt_slave_clock_in = mdc_q;
    assign link.host_data_o = dout_q;
    assign link.host_data_oe = oe_q;
endmodule // msib_host

/* test/msib_bench.sv */
// Testbench: APB host end talks over the link to the device end.
// Assumes the bench answers the device's register and shared buses.
`timescale 1ns/1ns
`include "msib_defines.svh"
module msib_bench;
    import msib_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, phy_address_choice = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, csr_rdata = 32'h0, shb_rdata = 32'h0;
    logic [31:0] prdata, csr_addr, csr_wdata, shb_addr, shb_wdata, la, ld, sa, sd, r, e;
    logic pready, pslverr, pin_takeover, csr_req, csr_wr, shb_req, shb_wr, lw, sw, s;
    logic csr_ack = 0, csr_err = 0, shb_ack = 0, shb_err = 0;
    logic [15:0] q;
    int n_fail = 0, compares = 0, n_csr = 0, n_shb = 0, n0;
    always #5 pclk = ~pclk;
    msib_link_if msib_link_if_i ();
    msib_host msib_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(msib_link_if_i));
    msib_device msib_device_i (.pclk(pclk), .presetn(presetn), .link(msib_link_if_i), .strap_slave_en(1'b1),
        .strap_addr_sel(1'b0), .phy_address_choice(phy_address_choice), .pin_takeover(pin_takeover),
        .csr_req(csr_req), .csr_wr(csr_wr), .csr_addr(csr_addr), .csr_wdata(csr_wdata), .csr_ack(csr_ack),
        .csr_err(csr_err), .csr_rdata(csr_rdata), .shb_req(shb_req), .shb_wr(shb_wr), .shb_addr(shb_addr),
        .shb_wdata(shb_wdata), .shb_ack(shb_ack), .shb_err(shb_err), .shb_rdata(shb_rdata));
    msib_link_sva msib_link_sva_i (.pclk(pclk), .presetn(presetn),
        .mgmt_slave_clock_in(msib_link_if_i.mgmt_slave_clock_in), .host_data_o(msib_link_if_i.host_data_o),
        .host_data_oe(msib_link_if_i.host_data_oe), .dev_data_o(msib_link_if_i.dev_data_o),
        .dev_data_oe(msib_link_if_i.dev_data_oe), .mgmt_slave_data_io(msib_link_if_i.mgmt_slave_data_io));
    ////////////////////////////////////////////////////////////////
    // Responders answer one cycle after a request and log it.
    always @(posedge pclk) begin
        csr_ack <= csr_req & ~csr_ack;
        csr_err <= csr_addr == 32'h00000bad;
        csr_rdata <= csr_addr ^ 32'ha5a5c3c3;
        shb_ack <= shb_req & ~shb_ack;
        shb_err <= shb_addr == 32'h00000104;
        shb_rdata <= ~shb_addr;
        if (csr_req & ~csr_ack) begin
            n_csr <= n_csr + 1;
            {lw, la, ld} <= {csr_wr, csr_addr, csr_wdata};
        end
        if (shb_req & ~shb_ack) begin
            n_shb <= n_shb + 1;
            {sw, sa, sd} <= {shb_wr, shb_addr, shb_wdata};
        end
    end
    ////////////////////////////////////////////////////////////////
    task summarize;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input string nm, input logic [64:0] seen, input logic [64:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        s = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task lnk(input logic rd, input logic [4:0] g, input logic [15:0] d);
        apb(1'b1, `MS_A_CMD, {7'h00, rd, 3'h0, g, d});
        do begin
            apb(1'b0, `MS_A_STAT, 32'h0);
        end while (r[0] !== 1'b0);
        apb(1'b0, `MS_A_RDATA, 32'h0);
        q = r[15:0];
    endtask
    task seta(input logic [31:0] a);
        lnk(1'b0, 5'h00, a[15:0]);
        lnk(1'b0, 5'h01, a[31:16]);
    endtask
    initial begin
        #600000;
        n_fail++;
        summarize;
    end
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        chk("takeover", pin_takeover, 1'b1);
        seta((32'h000048d0 & 32'h00ffffff) >> 2);
        lnk(1'b0, 5'h02, 16'hbeef);
        lnk(1'b0, 5'h03, 16'hcafe);
        chk("csr write", {lw, la, ld}, {1'b1, 32'h00001234, 32'hcafebeef});
        lnk(1'b1, 5'h03, 16'h0);
        e = 32'h00001234 ^ 32'ha5a5c3c3;
        n0 = n_csr;
        lnk(1'b1, 5'h02, 16'h0);
        chk("data low", q, e[15:0]);
        lnk(1'b1, 5'h05, 16'h0);
        chk("data high", q, e[31:16]);
        chk("passive count", n_csr, n0);
        lnk(1'b1, 5'h04, 16'h0);
        lnk(1'b1, 5'h03, 16'h0);
        chk("next word", la, 32'h00001235);
        seta(32'h00000bad);
        lnk(1'b1, 5'h03, 16'h0);
        lnk(1'b1, 5'h02, 16'h0);
        chk("error low", q, 16'h8888);
        lnk(1'b1, 5'h06, 16'h0);
        chk("status", q & 16'h0005, 16'h0004);
        apb(1'b1, `MS_A_PHY, 32'h00000003);
        lnk(1'b0, 5'h00, 16'h7777);
        phy_address_choice <= 1'b1;
        apb(1'b1, `MS_A_PHY, 32'h00000001);
        lnk(1'b0, 5'h00, 16'h6666);
        apb(1'b1, `MS_A_PHY, 32'h00000002);
        lnk(1'b1, 5'h00, 16'h0);
        chk("phy address", q, 16'h0bad);
        seta(32'h00fff801);
        lnk(1'b0, 5'h02, 16'h0100);
        lnk(1'b0, 5'h03, 16'h0000);
        seta(32'h00fff802);
        lnk(1'b0, 5'h02, 16'h5678);
        lnk(1'b0, 5'h03, 16'h1234);
        chk("bus write", {sw, sa, sd}, {1'b1, 32'h00000100, 32'h12345678});
        seta(32'h00fff803);
        lnk(1'b1, 5'h03, 16'h0);
        lnk(1'b1, 5'h03, 16'h0);
        chk("bus step", {sw, sa}, {1'b0, 32'h00000104});
        lnk(1'b1, 5'h02, 16'h0);
        chk("bus read", q, 16'hfeff);
        seta(32'h00fff804);
        n0 = n_shb;
        lnk(1'b1, 5'h03, 16'h0);
        lnk(1'b1, 5'h02, 16'h0);
        chk("fault data", q, 16'h8888);
        chk("passive bus", n_shb, n0);
        seta(32'h00fff800);
        lnk(1'b1, 5'h03, 16'h0);
        lnk(1'b1, 5'h02, 16'h0);
        chk("fault flag", q & 16'h0003, 16'h0002);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped", {s, r}, {1'b1, 32'h0});
        summarize;
    end
endmodule // msib_bench

/* test/msib_link_sva.sv */
// Checker of the serial management link wire.
// Assumes it sits beside the link interface, clocked by pclk.
`timescale 1ns/1ns
module msib_link_sva (
    // Clock, reset and link wire.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic mgmt_slave_clock_in,
    input wire logic host_data_o,
    input wire logic host_data_oe,
    input wire logic dev_data_o,
    input wire logic dev_data_oe,
    input wire logic mgmt_slave_data_io
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [8:0] oe_cnt_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) oe_cnt_q <= 9'h000;
        else oe_cnt_q <= dev_data_oe ? oe_cnt_q + 9'h001 : 9'h000;
    end
    property p_one_drv; !(host_data_oe && dev_data_oe); endproperty
    a_one_drv: assert property (p_one_drv) else $error("both ends drive");
    property p_dev_chg; $changed(dev_data_o) && dev_data_oe |-> mgmt_slave_clock_in; endproperty
    a_dev_chg: assert property (p_dev_chg) else $error("device bit moved off rise");
    property p_oe_on; $rose(dev_data_oe) |-> mgmt_slave_clock_in && !$past(host_data_oe); endproperty
    a_oe_on: assert property (p_oe_on) else $error("device drive start off rise");
    property p_oe_off; $fell(dev_data_oe) |-> mgmt_slave_clock_in; endproperty
    a_oe_off: assert property (p_oe_off) else $error("device release off rise");
    property p_oe_len; $fell(dev_data_oe) |-> $past(oe_cnt_q) >= 9'd250 && $past(oe_cnt_q) <= 9'd262; endproperty
    a_oe_len: assert property (p_oe_len) else $error("device drive not sixteen bits");
    property p_host_chg; $changed(host_data_o) |-> !mgmt_slave_clock_in; endproperty
    a_host_chg: assert property (p_host_chg) else $error("host bit moved while clock high");
    property p_clk_hi; $rose(mgmt_slave_clock_in) |-> mgmt_slave_clock_in [*8] ##1 !mgmt_slave_clock_in; endproperty
    a_clk_hi: assert property (p_clk_hi) else $error("clock high phase wrong");
    property p_clk_lo; $fell(mgmt_slave_clock_in) |-> !mgmt_slave_clock_in [*8]; endproperty
    a_clk_lo: assert property (p_clk_lo) else $error("clock low phase short");
    c_dev: cover property ($rose(dev_data_oe));
    c_zero: cover property (dev_data_oe && !mgmt_slave_data_io);
    c_frame: cover property ($fell(host_data_oe));
endmodule // msib_link_sva
